// *** link_gen3_pkg.sv ***
// Purpose: shared constants for the third-generation link configuration bank
// Assumes: configuration accesses carry a space select, a byte offset and a full word
// Notes:   indirect link-unit registers sit behind an index/data pair in bridge space

package link_gen3_pkg;

  // address spaces seen on the configuration port
  localparam logic [1:0] SPACE_BRIDGE  = 2'h0;
  localparam logic [1:0] SPACE_CLOCK   = 2'h1;

  // bridge and clock space byte offsets
  localparam logic [7:0] OFF_CAP_PTR   = 8'h34;
  localparam logic [7:0] OFF_CAP_HDR   = 8'hC4;
  localparam logic [7:0] OFF_RETRY     = 8'h44;
  localparam logic [7:0] OFF_UNLOCK    = 8'h9C;
  localparam logic [7:0] OFF_T0        = 8'hA0;
  localparam logic [7:0] OFF_DEEMPH    = 8'hA4;
  localparam logic [7:0] OFF_FEATURE   = 8'hAC;
  localparam logic [7:0] OFF_WIDTH     = 8'hC8;
  localparam logic [7:0] OFF_FREQ      = 8'hD0;
  localparam logic [7:0] OFF_BIAS      = 8'hD8;
  localparam logic [7:0] OFF_IND_INDEX = 8'h94;
  localparam logic [7:0] OFF_IND_DATA  = 8'h98;

  // indirect link-unit register indices
  localparam logic [6:0] IND_TRAIN     = 7'h15;
  localparam logic [6:0] IND_DRIVE     = 7'h2A;

  // capability header contents
  localparam logic [7:0] CAP_ID        = 8'h08;
  localparam logic [7:0] CAP_TYPE      = 8'hD0;

  // storage slots of the register file
  localparam int unsigned NUM_REGS     = 10;
  localparam logic [3:0] IDX_RETRY     = 4'h0;
  localparam logic [3:0] IDX_UNLOCK    = 4'h1;
  localparam logic [3:0] IDX_T0        = 4'h2;
  localparam logic [3:0] IDX_DEEMPH    = 4'h3;
  localparam logic [3:0] IDX_FEATURE   = 4'h4;
  localparam logic [3:0] IDX_WIDTH     = 4'h5;
  localparam logic [3:0] IDX_FREQ      = 4'h6;
  localparam logic [3:0] IDX_BIAS      = 4'h7;
  localparam logic [3:0] IDX_TRAIN     = 4'h8;
  localparam logic [3:0] IDX_DRIVE     = 4'h9;

  // field positions
  localparam int unsigned FREQ_LSB     = 8;
  localparam int unsigned RXW_LSB      = 24;
  localparam int unsigned TXW_LSB      = 28;
  localparam int unsigned RETRY_BIT    = 0;
  localparam int unsigned SCR_BIT      = 3;
  localparam int unsigned THR_BIT      = 14;
  localparam int unsigned DEEN_BIT     = 31;
  localparam int unsigned DELVL_LSB    = 24;
  localparam int unsigned TM4_BIT      = 22;
  localparam int unsigned UNLOCK_LSB   = 16;
  localparam int unsigned IND_WE_BIT   = 8;

  // reset values and write masks
  localparam logic [31:0] REG_RST      = 32'h0000_0000;
  localparam logic [8:0]  IND_IDX_RST  = 9'h000;
  localparam logic [31:0] MASK_ALL     = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_FREQ    = 32'h0000_FFFF;
  localparam logic [15:0] FREQ_CAP_DEF = 16'h7FF5;

  // link encodings
  localparam logic [2:0] WIDTH_16      = 3'h1;
  localparam logic [3:0] FREQ_GEN3_MIN = 4'h7;
  localparam logic [3:0] T0_COARSE_MAX = 4'hA;
  localparam int unsigned T0_UNIT_NS   = 100;

  // training-0 step factors in 100 ns units
  localparam logic [7:0] T0_STEP0      = 8'h01;
  localparam logic [7:0] T0_STEP1      = 8'h05;
  localparam logic [7:0] T0_STEP2      = 8'h14;
  localparam logic [7:0] T0_STEP3      = 8'hC8;

  // snapshot word layout handed to the link domain
  localparam int unsigned SN_FREQ_LSB  = 28;
  localparam int unsigned SN_RXW       = 27;
  localparam int unsigned SN_TXW       = 26;
  localparam int unsigned SN_BIAS_LSB  = 16;
  localparam int unsigned SN_RETRY     = 15;
  localparam int unsigned SN_SCR       = 14;
  localparam int unsigned SN_DEEN      = 13;
  localparam int unsigned SN_DELVL_LSB = 10;
  localparam int unsigned SN_T0_LSB    = 4;
  localparam int unsigned SN_THR       = 3;
  localparam int unsigned SN_TM4       = 2;
  localparam int unsigned SN_DRV_LSB   = 0;

endpackage : link_gen3_pkg

// *** sync_bit.sv ***
// Purpose: two-flop synchroniser for one level
// Assumes: synchronous active-high reset in the destination domain
// Notes:   the first stage feeds only the second stage

`timescale 1ns/1ps
`default_nettype none

module sync_bit (
  // destination clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // next values of both stages
  always_comb
  begin
    meta_d = srst ? 1'b0 : din;
    sync_d = srst ? 1'b0 : meta_q;
  end

  // register both stages
  always_ff @(posedge clock)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign dout = sync_q;

endmodule : sync_bit

`default_nettype wire

// *** link_gen3_mode_config.sv ***
// Purpose: third-generation link mode configuration bank with warm-reset apply
// Assumes: one configuration access per request, answered on the next edge
// Notes:   settings reach the link domain only after a warm reset releases

`timescale 1ns/1ps
`default_nettype none

module link_gen3_mode_config #(
  parameter logic [15:0] FREQ_CAP = link_gen3_pkg::FREQ_CAP_DEF
) (
  // core clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // link clock and reset
  input  wire logic        link_clock,
  input  wire logic        link_srst,
  // warm reset pin, active high
  input  wire logic        warm_reset,
  // configuration access
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [1:0]  cfg_space,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  // applied link settings
  output logic             link_applied,
  output logic [3:0]       link_freq_code,
  output logic             link_gen3_mode,
  output logic             link_freq_unsup,
  output logic             link_rx_width16,
  output logic             link_tx_width16,
  output logic [9:0]       link_pll_bias,
  output logic             link_retry_en,
  output logic             link_scramble_en,
  output logic             link_deemph_en,
  output logic [2:0]       link_deemph_level,
  output logic             link_throttle_dis,
  output logic             link_strict_tm4,
  output logic [1:0]       link_drive_strength,
  output logic [11:0]      link_t0_units,
  output logic             link_t0_reserved
);

  logic [31:0] regs_q [link_gen3_pkg::NUM_REGS];
  logic [31:0] regs_d [link_gen3_pkg::NUM_REGS];
  logic [8:0]  ind_idx_q;
  logic [8:0]  ind_idx_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        warm_s;
  logic        warm_prev_q;
  logic        warm_prev_d;
  logic        apply_tgl_q;
  logic        apply_tgl_d;
  logic [31:0] snap_q;
  logic [31:0] snap_d;
  logic        hit;
  logic [3:0]  hit_idx;
  logic        locked;
  logic        gen3_reg;
  logic        wr;

  // warm reset pin into the core domain
  sync_bit u_warm_sync (
    .clock (clock),
    .srst  (srst),
    .din   (warm_reset),
    .dout  (warm_s)
  );

  // decode the accessed storage slot
  always_comb
  begin
    hit     = 1'b1;
    hit_idx = link_gen3_pkg::IDX_RETRY;
    if (cfg_space == link_gen3_pkg::SPACE_CLOCK)
    begin
      hit     = (cfg_addr == link_gen3_pkg::OFF_BIAS);
      hit_idx = link_gen3_pkg::IDX_BIAS;
    end
    else if (cfg_space != link_gen3_pkg::SPACE_BRIDGE)
      hit = 1'b0;
    else if (cfg_addr == link_gen3_pkg::OFF_IND_DATA)
    begin
      hit     = (ind_idx_q[6:0] == link_gen3_pkg::IND_TRAIN) || (ind_idx_q[6:0] == link_gen3_pkg::IND_DRIVE);
      hit_idx = (ind_idx_q[6:0] == link_gen3_pkg::IND_TRAIN) ? link_gen3_pkg::IDX_TRAIN : link_gen3_pkg::IDX_DRIVE;
    end
    else
    begin
      case (cfg_addr)
        link_gen3_pkg::OFF_RETRY:   hit_idx = link_gen3_pkg::IDX_RETRY;
        link_gen3_pkg::OFF_UNLOCK:  hit_idx = link_gen3_pkg::IDX_UNLOCK;
        link_gen3_pkg::OFF_T0:      hit_idx = link_gen3_pkg::IDX_T0;
        link_gen3_pkg::OFF_DEEMPH:  hit_idx = link_gen3_pkg::IDX_DEEMPH;
        link_gen3_pkg::OFF_FEATURE: hit_idx = link_gen3_pkg::IDX_FEATURE;
        link_gen3_pkg::OFF_WIDTH:   hit_idx = link_gen3_pkg::IDX_WIDTH;
        link_gen3_pkg::OFF_FREQ:    hit_idx = link_gen3_pkg::IDX_FREQ;
        default:                    hit     = 1'b0;
      endcase
    end
  end

  assign locked   = (regs_q[link_gen3_pkg::IDX_UNLOCK][link_gen3_pkg::UNLOCK_LSB +: 2] != 2'h0);
  assign gen3_reg = (hit_idx == link_gen3_pkg::IDX_RETRY) || (hit_idx == link_gen3_pkg::IDX_T0) ||
                    (hit_idx == link_gen3_pkg::IDX_DEEMPH) || (hit_idx == link_gen3_pkg::IDX_FEATURE);
  assign wr       = cfg_req && cfg_we && hit && !(locked && gen3_reg);

  // register file writes; boot values writable at once
  always_comb
  begin
    for (int i = 0; i < link_gen3_pkg::NUM_REGS; i++)
      regs_d[i] = regs_q[i];
    ind_idx_d = ind_idx_q;
    if (wr)
    begin
      // upper half of the frequency word is read-only
      if (hit_idx == link_gen3_pkg::IDX_FREQ)
        regs_d[hit_idx] = cfg_wdata & link_gen3_pkg::MASK_FREQ;
      else
        regs_d[hit_idx] = cfg_wdata & link_gen3_pkg::MASK_ALL;
    end
    if (cfg_req && cfg_we && (cfg_space == link_gen3_pkg::SPACE_BRIDGE) &&
        (cfg_addr == link_gen3_pkg::OFF_IND_INDEX))
      ind_idx_d = cfg_wdata[8:0];
    if (srst)
    begin
      for (int i = 0; i < link_gen3_pkg::NUM_REGS; i++)
        regs_d[i] = link_gen3_pkg::REG_RST;
      ind_idx_d = link_gen3_pkg::IND_IDX_RST;
    end
  end

  // storage cleared only by the core reset, never by warm reset
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < link_gen3_pkg::NUM_REGS; i++)
      regs_q[i] <= regs_d[i];
    ind_idx_q <= ind_idx_d;
  end

  // read answer, one cycle after the request
  always_comb
  begin
    ack_d   = cfg_req && !srst;
    rdata_d = 32'h0000_0000;
    if (cfg_req && !cfg_we)
    begin
      if ((cfg_space == link_gen3_pkg::SPACE_BRIDGE) && (cfg_addr == link_gen3_pkg::OFF_CAP_PTR))
        rdata_d = {24'h00_0000, link_gen3_pkg::OFF_CAP_HDR};
      else if ((cfg_space == link_gen3_pkg::SPACE_BRIDGE) && (cfg_addr == link_gen3_pkg::OFF_CAP_HDR))
        rdata_d = {link_gen3_pkg::CAP_TYPE, 16'h0000, link_gen3_pkg::CAP_ID};
      else if ((cfg_space == link_gen3_pkg::SPACE_BRIDGE) && (cfg_addr == link_gen3_pkg::OFF_IND_INDEX))
        rdata_d = {23'h00_0000, ind_idx_q};
      else if (hit && (hit_idx == link_gen3_pkg::IDX_FREQ))
        rdata_d = {FREQ_CAP, regs_q[hit_idx][15:0]};
      else if (hit)
        rdata_d = regs_q[hit_idx];
    end
    if (srst)
      rdata_d = 32'h0000_0000;
  end

  // answer registers
  always_ff @(posedge clock)
  begin
    ack_q   <= ack_d;
    rdata_q <= rdata_d;
  end

  assign cfg_ack   = ack_q;
  assign cfg_rdata = rdata_q;

  // capture settings at warm reset release and flag the link
  always_comb
  begin
    warm_prev_d = warm_s;
    apply_tgl_d = apply_tgl_q;
    snap_d      = snap_q;
    if (warm_prev_q && !warm_s)
    begin
      apply_tgl_d = !apply_tgl_q;
      snap_d = {regs_q[link_gen3_pkg::IDX_FREQ][link_gen3_pkg::FREQ_LSB +: 4],
                (regs_q[link_gen3_pkg::IDX_WIDTH][link_gen3_pkg::RXW_LSB +: 3] == link_gen3_pkg::WIDTH_16),
                (regs_q[link_gen3_pkg::IDX_WIDTH][link_gen3_pkg::TXW_LSB +: 3] == link_gen3_pkg::WIDTH_16),
                regs_q[link_gen3_pkg::IDX_BIAS][9:0],
                regs_q[link_gen3_pkg::IDX_RETRY][link_gen3_pkg::RETRY_BIT],
                regs_q[link_gen3_pkg::IDX_FEATURE][link_gen3_pkg::SCR_BIT],
                regs_q[link_gen3_pkg::IDX_DEEMPH][link_gen3_pkg::DEEN_BIT],
                regs_q[link_gen3_pkg::IDX_DEEMPH][link_gen3_pkg::DELVL_LSB +: 3],
                regs_q[link_gen3_pkg::IDX_T0][5:0],
                regs_q[link_gen3_pkg::IDX_FEATURE][link_gen3_pkg::THR_BIT],
                regs_q[link_gen3_pkg::IDX_TRAIN][link_gen3_pkg::TM4_BIT],
                regs_q[link_gen3_pkg::IDX_DRIVE][1:0]};
    end
    if (srst)
    begin
      warm_prev_d = 1'b0;
      apply_tgl_d = 1'b0;
      snap_d      = link_gen3_pkg::REG_RST;
    end
  end

  // apply handshake registers
  always_ff @(posedge clock)
  begin
    warm_prev_q <= warm_prev_d;
    apply_tgl_q <= apply_tgl_d;
    snap_q      <= snap_d;
  end

  // link domain: toggle crossing, snapshot stable while it travels
  logic        tgl_s;
  logic        tgl_seen_q;
  logic        tgl_seen_d;
  logic [31:0] act_q;
  logic [31:0] act_d;
  logic        applied_q;
  logic        applied_d;
  logic        gen3_q;
  logic        gen3_d;
  logic        unsup_q;
  logic        unsup_d;
  logic [11:0] t0_q;
  logic [11:0] t0_d;
  logic        t0_res_q;
  logic        t0_res_d;
  logic [7:0]  step;
  logic [3:0]  mult;

  sync_bit u_apply_sync (
    .clock (link_clock),
    .srst  (link_srst),
    .din   (apply_tgl_q),
    .dout  (tgl_s)
  );

  // next applied settings and derived link controls
  always_comb
  begin
    tgl_seen_d = tgl_s;
    applied_d  = (tgl_s != tgl_seen_q);
    act_d      = applied_d ? snap_q : act_q;
    // link reset returns to 200MHz 8-bit boot mode
    if (link_srst)
    begin
      tgl_seen_d = 1'b0;
      applied_d  = 1'b0;
      act_d      = link_gen3_pkg::REG_RST;
    end
    gen3_d  = (act_d[link_gen3_pkg::SN_FREQ_LSB +: 4] >= link_gen3_pkg::FREQ_GEN3_MIN);
    unsup_d = !FREQ_CAP[act_d[link_gen3_pkg::SN_FREQ_LSB +: 4]];
    // training-0 decode in 100 ns units
    mult = act_d[link_gen3_pkg::SN_T0_LSB +: 4];
    case (act_d[link_gen3_pkg::SN_T0_LSB + 4 +: 2])
      2'h0:    step = link_gen3_pkg::T0_STEP0;
      2'h1:    step = link_gen3_pkg::T0_STEP1;
      2'h2:    step = link_gen3_pkg::T0_STEP2;
      default: step = link_gen3_pkg::T0_STEP3;
    endcase
    t0_res_d = (step == link_gen3_pkg::T0_STEP3) && (mult > link_gen3_pkg::T0_COARSE_MAX);
    t0_d     = t0_res_d ? 12'h000 : (12'(mult) * 12'(step)); // widen before multiplying
  end

  // link domain registers
  always_ff @(posedge link_clock)
  begin
    tgl_seen_q <= tgl_seen_d;
    applied_q  <= applied_d;
    act_q      <= act_d;
    gen3_q     <= gen3_d;
    unsup_q    <= unsup_d;
    t0_q       <= t0_d;
    t0_res_q   <= t0_res_d;
  end

  assign link_applied        = applied_q;
  assign link_freq_code      = act_q[link_gen3_pkg::SN_FREQ_LSB +: 4];
  assign link_gen3_mode      = gen3_q;
  assign link_freq_unsup     = unsup_q;
  assign link_rx_width16     = act_q[link_gen3_pkg::SN_RXW];
  assign link_tx_width16     = act_q[link_gen3_pkg::SN_TXW];
  assign link_pll_bias       = act_q[link_gen3_pkg::SN_BIAS_LSB +: 10];
  assign link_retry_en       = act_q[link_gen3_pkg::SN_RETRY];
  assign link_scramble_en    = act_q[link_gen3_pkg::SN_SCR];
  assign link_deemph_en      = act_q[link_gen3_pkg::SN_DEEN];
  assign link_deemph_level   = act_q[link_gen3_pkg::SN_DELVL_LSB +: 3];
  assign link_throttle_dis   = act_q[link_gen3_pkg::SN_THR];
  assign link_strict_tm4     = act_q[link_gen3_pkg::SN_TM4];
  assign link_drive_strength = act_q[link_gen3_pkg::SN_DRV_LSB +: 2];
  assign link_t0_units       = t0_q;
  assign link_t0_reserved    = t0_res_q;

  // capability header read answer
  property p_cap_hdr;
    @(posedge clock) disable iff (srst)
    cfg_req && !cfg_we && (cfg_space == 2'h0) && (cfg_addr == 8'hC4)
      |=> cfg_ack && (cfg_rdata[7:0] == 8'h08) && (cfg_rdata[31:24] == 8'hD0);
  endproperty
  a_cap_hdr: assert property (p_cap_hdr) else $error("capability header wrong");

  // frequency code write lands in the stored word
  property p_freq_wr;
    @(posedge clock) disable iff (srst)
    cfg_req && cfg_we && (cfg_space == 2'h0) && (cfg_addr == 8'hD0)
      |=> regs_q[6][11:8] == $past(cfg_wdata[11:8]);
  endproperty
  a_freq_wr: assert property (p_freq_wr) else $error("frequency code not stored");

  // locked training-0 register ignores writes
  property p_lock;
    @(posedge clock) disable iff (srst)
    locked && cfg_req && cfg_we && (cfg_space == 2'h0) && (cfg_addr == 8'hA0)
      |=> $stable(regs_q[2]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed");

  // retry enable write takes effect when unlocked
  property p_retry;
    @(posedge clock) disable iff (srst)
    !locked && cfg_req && cfg_we && (cfg_space == 2'h0) && (cfg_addr == 8'h44) && cfg_wdata[0]
      |=> regs_q[0][0];
  endproperty
  a_retry: assert property (p_retry) else $error("retry enable not stored");

  // indirect training register written through the data window
  property p_ind;
    @(posedge clock) disable iff (srst)
    cfg_req && cfg_we && (cfg_space == 2'h0) && (cfg_addr == 8'h98) && (ind_idx_q[6:0] == 7'h15)
      |=> regs_q[8] == $past(cfg_wdata);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect write lost");

  // stored settings change only by a write, warm reset or not
  property p_keep;
    @(posedge clock) disable iff (srst)
    !(cfg_req && cfg_we) |=> $stable(regs_q[6]) && $stable(regs_q[5]);
  endproperty
  a_keep: assert property (p_keep) else $error("settings changed without write");

  // applied pulse loads the snapshot into the link controls
  property p_apply;
    @(posedge link_clock) disable iff (link_srst)
    applied_d |=> (link_freq_code == $past(snap_q[31:28])) && (link_pll_bias == $past(snap_q[25:16]));
  endproperty
  a_apply: assert property (p_apply) else $error("warm reset apply wrong");

  // link reset returns to boot frequency and narrow width
  property p_boot;
    @(posedge link_clock)
    link_srst |=> (link_freq_code == 4'h0) && !link_rx_width16 && !link_tx_width16 && !link_gen3_mode;
  endproperty
  a_boot: assert property (p_boot) else $error("boot mode not restored");

  // coarse step multipliers above 0xA are flagged reserved
  property p_t0_res;
    @(posedge link_clock) disable iff (link_srst)
    (act_q[9:8] == 2'h3) && (act_q[7:4] > 4'hA) |-> link_t0_reserved && (link_t0_units == 12'h000);
  endproperty
  a_t0_res: assert property (p_t0_res) else $error("reserved time not flagged");

endmodule : link_gen3_mode_config

`default_nettype wire

// *** link_peer.sv ***
// Purpose: processor-side link settings holder facing the configured device
// Assumes: software loads the same codes into both ends before the warm reset
// Notes:   agree rises when the applied device settings match this side and both widths are 16 bits
`timescale 1ns/1ps
`default_nettype none

module link_peer (
  // link clock and reset
  input  wire logic        link_clock,
  input  wire logic        link_srst,
  // processor-side codes loaded by software
  input  wire logic [3:0]  freq_code,
  input  wire logic [5:0]  t0_code,
  // applied device settings
  input  wire logic [3:0]  dev_freq,
  input  wire logic        dev_rx16,
  input  wire logic        dev_tx16,
  input  wire logic [11:0] dev_t0,
  // compare result
  output logic             agree
);
  logic [11:0] own_t0;
  logic        deemph_on;

  assign deemph_on = 1'b1;

  always_comb
  begin
    case (t0_code[5:4])
      2'h0:    own_t0 = 12'(t0_code[3:0]);
      2'h1:    own_t0 = 12'(t0_code[3:0]) * 12'h005;
      2'h2:    own_t0 = 12'(t0_code[3:0]) * 12'h014;
      default: own_t0 = (t0_code[3:0] > 4'hA) ? 12'h000 : 12'(t0_code[3:0]) * 12'h0C8;
    endcase
  end

  // same code, same training-0 time, both widths 16 bits
  always_ff @(posedge link_clock)
  begin
    agree <= !link_srst && deemph_on && (dev_freq == freq_code) && dev_rx16 && dev_tx16 && (dev_t0 == own_t0);
  end
endmodule : link_peer
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench for the third-generation link configuration bank
// Assumes: accesses answered at the edge that takes the request
// Notes:   random settings per round, applied through a warm reset pulse
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR at %0t got %0h expected %0h", $time, g, e); end end

module testbench;
  logic clock = 0, srst = 1, link_clock = 0, link_srst = 1, warm_reset = 0;
  logic cfg_req = 0, cfg_we = 0, cfg_ack, link_applied, gen3, unsup, rx16, tx16, retry, scr;
  logic deen, thr, tm4, t0_res, agree, seen;
  logic [1:0]  cfg_space = 0, drv;
  logic [7:0]  cfg_addr = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata, rd;
  logic [3:0]  fcode, code;
  logic [2:0]  lvl, dlvl;
  logic [9:0]  bias, pbias;
  logic [11:0] t0u;
  logic [5:0]  t0;
  logic [3:0]  fl;
  logic        w;
  int          bad_count = 0, cmp_count = 0;

  // core and link clocks
  always #5 clock = ~clock;
  always #62.5 link_clock = ~link_clock;

  link_gen3_mode_config #(.FREQ_CAP(link_gen3_pkg::FREQ_CAP_DEF)) DUT (
    .clock(clock), .srst(srst), .link_clock(link_clock), .link_srst(link_srst), .warm_reset(warm_reset),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_space(cfg_space), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .link_applied(link_applied),
    .link_freq_code(fcode), .link_gen3_mode(gen3), .link_freq_unsup(unsup), .link_rx_width16(rx16),
    .link_tx_width16(tx16), .link_pll_bias(pbias), .link_retry_en(retry), .link_scramble_en(scr),
    .link_deemph_en(deen), .link_deemph_level(dlvl), .link_throttle_dis(thr), .link_strict_tm4(tm4),
    .link_drive_strength(drv), .link_t0_units(t0u), .link_t0_reserved(t0_res));

  link_peer peer (.link_clock(link_clock), .link_srst(link_srst), .freq_code(code), .t0_code(t0),
    .dev_freq(fcode), .dev_rx16(rx16), .dev_tx16(tx16), .dev_t0(t0u), .agree(agree));

  // expected training-0 time in 100 ns units
  function automatic logic [11:0] exp_t0(input logic [5:0] c);
    logic [11:0] m;
    m = c[5] ? (c[4] ? 12'h0C8 : 12'h014) : (c[4] ? 12'h005 : 12'h001);
    if (c[5:4] == 2'h3 && c[3:0] > 4'hA)
      return 12'h000;
    return 12'(c[3:0]) * m;
  endfunction : exp_t0

  // one configuration access, answer sampled one cycle after the request
  task automatic acc(input logic we, input logic [1:0] sp, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    cfg_req <= 1'b1; cfg_we <= we; cfg_space <= sp; cfg_addr <= a; cfg_wdata <= wd;
    @(posedge clock);
    cfg_req <= 1'b0;
    #1;
    rd = cfg_rdata;
    `CHK(cfg_ack, 1'b1)
  endtask : acc

  // pulse warm reset and wait for the link to load the snapshot
  task automatic warm_apply();
    seen = 1'b0;
    @(posedge clock);
    warm_reset <= 1'b1;
    repeat (3) @(posedge clock);
    warm_reset <= 1'b0;
    for (int i = 0; i < 40 && !seen; i++)
    begin
      @(posedge link_clock);
      #1;
      seen = (link_applied === 1'b1);
    end
    #1;
  endtask : warm_apply

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // watchdog against a hang
  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end

  // main sequence
  initial
  begin
    void'($urandom(70924));
    code = 4'h0;
    t0 = 6'h00;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (30) @(posedge clock);
    link_srst <= 1'b0;
    acc(0, 2'h0, 8'h34, 0); `CHK(rd[7:0], 8'hC4)
    acc(0, 2'h0, 8'hC4, 0); `CHK({rd[31:24], rd[7:0]}, 16'hD008)
    acc(1, 2'h0, 8'hD0, 32'hFFFF_FF00);
    acc(0, 2'h0, 8'hD0, 0); `CHK(rd, {link_gen3_pkg::FREQ_CAP_DEF, 16'hFF00})
    acc(0, 2'h2, 8'hD8, 0); `CHK(rd, 32'h0000_0000)
    $display("test capability done");
    acc(1, 2'h0, 8'h9C, 32'h0003_0000);
    acc(1, 2'h0, 8'h44, 32'h0000_0001);
    acc(0, 2'h0, 8'h44, 0); `CHK(rd, 32'h0000_0000)
    acc(1, 2'h0, 8'hA0, 32'h0000_002A);
    acc(0, 2'h0, 8'hA0, 0); `CHK(rd, 32'h0000_0000)
    acc(1, 2'h0, 8'h9C, 32'h0000_0000);
    $display("test unlock done");
    for (int k = 0; k < 4; k++)
    begin
      code = (k == 0) ? 4'hE : 4'h7 + 4'($urandom % 8);
      t0 = (k == 0) ? 6'h3B : 6'($urandom);
      w = (k == 0) ? 1'b0 : 1'b1;
      bias = 10'($urandom);
      lvl = 3'($urandom);
      fl = 4'($urandom);
      acc(1, 2'h0, 8'hD0, {20'h0, code, 8'h00});
      acc(1, 2'h0, 8'hC8, {1'b0, 2'b0, w, 1'b0, 2'b0, w, 24'h0});
      acc(1, 2'h1, 8'hD8, {22'h0, bias});
      acc(1, 2'h0, 8'h44, {31'h0, fl[0]});
      acc(1, 2'h0, 8'hAC, {17'h0, fl[2], 10'h0, fl[1], 3'h0});
      acc(1, 2'h0, 8'hA4, {1'b1, 4'h0, lvl, 24'h0});
      acc(1, 2'h0, 8'hA0, {26'h0, t0});
      acc(1, 2'h0, 8'h94, 32'h0000_0115);
      acc(1, 2'h0, 8'h98, {9'h0, fl[3], 22'h0});
      acc(1, 2'h0, 8'h94, 32'h0000_012A);
      acc(1, 2'h0, 8'h98, 32'h0000_0001);
      acc(0, 2'h0, 8'h98, 0); `CHK(rd, 32'h0000_0001)
      acc(0, 2'h0, 8'hA0, 0); `CHK(rd, {26'h0, t0})
      acc(0, 2'h1, 8'hD8, 0); `CHK(rd[9:0], bias)
      warm_apply(); `CHK(seen, 1'b1)
      `CHK(fcode, code)
      `CHK(gen3, 1'b1)
      `CHK(unsup, ~link_gen3_pkg::FREQ_CAP_DEF[code])
      `CHK({rx16, tx16}, {w, w})
      `CHK(pbias, bias)
      `CHK({retry, scr, thr}, {fl[0], fl[1], fl[2]})
      `CHK({deen, dlvl}, {1'b1, lvl})
      `CHK(tm4, fl[3])
      `CHK(drv, 2'h1)
      `CHK(t0u, exp_t0(t0))
      `CHK(t0_res, (t0[5:4] == 2'h3 && t0[3:0] > 4'hA))
      @(posedge link_clock);
      #1;
      `CHK(agree, w)
      acc(0, 2'h0, 8'h44, 0); `CHK(rd, {31'h0, fl[0]})
      acc(1, 2'h0, 8'hD0, {20'h0, code ^ 4'h1, 8'h00});
      repeat (40) @(posedge clock);
      `CHK(fcode, code)
      $display("test round %0d done", k);
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
